// *** src/csr_pkg.sv ***
package csr_pkg;
  // Geometry
  localparam int NUM_CTR = 8;
  localparam int CTR_W = 32;
  // Register byte offsets (per-counter block of 5 words at 0x20 * n)
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_LOAD = 12'h004;
  localparam logic [11:0] OFF_COUNT = 12'h008;
  localparam logic [11:0] OFF_LATCH = 12'h00C;
  localparam logic [11:0] OFF_CMD = 12'h010;
  localparam logic [11:0] OFF_GLOBAL = 12'h100;
  localparam logic [11:0] OFF_STATUS = 12'h104;
  localparam int CTR_STRIDE_SHIFT = 5;
  // CTRL fields
  localparam int F_EN = 0;
  localparam int F_SRC_EDGE = 1;
  localparam int F_TOGGLE = 2;
  localparam int F_POL = 3;
  localparam int F_OUT_EN = 4;
  localparam int F_ARM_HW = 5;
  localparam int F_PAIR_GATE = 6;
  localparam int F_AUX_DIR = 7;
  localparam int F_CONT = 8;
  localparam int F_AUX_MODE = 9;   // 2 bits
  localparam int F_AUX_EDGE = 11;
  localparam int F_TB_SEL = 12;    // 2 bits
  localparam int F_GATE_EN = 14;
  localparam int F_ARM_SEL = 15;   // 3 bits: trigger bus line
  localparam int CTRL_W = 18;
  localparam logic [CTRL_W-1:0] CTRL_RST = 18'h00000;
  // GLOBAL fields
  localparam int G_TB_DRIVE = 0;
  localparam int G_PLL_EN = 1;
  localparam int G_PXI = 2;
  localparam logic [2:0] GLOBAL_RST = 3'h2;
  // CMD fields
  localparam int C_ARM = 0;
  localparam int C_DISARM = 1;
  // Timing
  localparam int CLK_KHZ = 25000;
  localparam int REF_KHZ = 10000;
  localparam int SLOW_KHZ = 100;
  localparam int MID_KHZ = 20000;
  localparam int SLOW_DIV = CLK_KHZ / SLOW_KHZ;
  localparam int REF_LOSS_CYC = 16;
  localparam int SYNC_LINE = 7;
  localparam int STAR_LINE = 6;
  // Aux modes
  typedef enum logic [1:0] {
    CSR_AUX_NONE = 2'b00,
    CSR_AUX_STARTSTOP = 2'b01,
    CSR_AUX_LATCH = 2'b10,
    CSR_AUX_EVENT = 2'b11
  } csr_aux_t;
endpackage

// *** src/csr_top.sv ***
`timescale 1ns/1ns
// Register map, byte addresses; counter n block starts at n * 0x20
//   0x00  control word, 18 bits
//   0x04  load value; a write also sets the live count
//   0x08  live count, read only
//   0x0C  count captured by the auxiliary input
//   0x10  command: bit 0 arm, bit 1 disarm, bit 2 clear event flag
//   0x100 global: bit 0 drive line 7, bit 1 lock enable, bit 2 backplane
//   0x104 status: armed, running, event flags, reference present
//   Any other address answers with an error and has no effect.
//
// Control word fields
//   bit 0      counter enable
//   bit 1      count on the falling edge of the count input
//   bit 2      toggle the output instead of pulsing it
//   bit 3      invert the output polarity
//   bit 4      drive the output pin
//   bit 5      arm from the selected trigger line
//   bit 6      gate taken from the partner counter output
//   bit 7      auxiliary level selects down counting
//   bit 8      continuous run, no disarm at rollover
//   bits 10:9  auxiliary use: none, start/stop, latch, event
//   bit 11     auxiliary acts on its falling edge
//   bits 13:12 timebase: pin, slow, mid rate, fast
//   bit 14     gate level pauses counting
//   bits 17:15 trigger line used for hardware arm
//
// Hazards and limits
//   Pins pass three flops plus an agree stage, so a pin change acts
//   about four clocks late; pulses shorter than that may be lost.
//   The mid-rate timebase is a fractional divider: ticks are not evenly
//   spaced, but the average rate is exact.
//   Read data is loaded in the setup cycle, so a read needs its setup.
//   Lines 0 to 5 carry counter outputs but their enables stay low.
//   The star line is an input only; it is passed on, never driven.
//   A counter gated by its partner sees the partner's polarity setting.
module csr_top
  import csr_pkg::*;
#(
  parameter int HAS_FAST = 1
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Counter pins
  input wire logic [NUM_CTR-1:0] counter_count_input,
  input wire logic [NUM_CTR-1:0] counter_gate_input,
  input wire logic [NUM_CTR-1:0] counter_auxiliary_input,
  output logic [NUM_CTR-1:0] counter_out_o,
  output logic [NUM_CTR-1:0] counter_out_oe,
  output logic [NUM_CTR-1:0] counter_terminal_output,
  // Trigger bus (8 open lines)
  input wire logic [7:0] trigger_sync_bus_i,
  output logic [7:0] trigger_sync_bus_o,
  output logic [7:0] trigger_sync_bus_oe,
  // Backplane
  input wire logic backplane_ref_clk,
  output logic star_trigger,
  output logic ref_locked
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, change accepted when stages 2 and 3 agree
  // sync inputs
  localparam int NSYNC = 3 * NUM_CTR + 9;
  logic [NSYNC-1:0] sync1, sync2, sync3, clean;
  wire [NSYNC-1:0] raw_pins = {backplane_ref_clk, trigger_sync_bus_i, counter_auxiliary_input,
                               counter_gate_input, counter_count_input};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      clean <= '0;
    end else begin
      sync1 <= raw_pins;
      sync2 <= sync1;
      sync3 <= sync2;
      clean <= (sync2 == sync3) ? sync3 : clean;
    end
  end
  wire [NUM_CTR-1:0] src_s = clean[NUM_CTR-1:0];
  wire [NUM_CTR-1:0] gate_s = clean[2*NUM_CTR-1:NUM_CTR];
  wire [NUM_CTR-1:0] aux_s = clean[3*NUM_CTR-1:2*NUM_CTR];
  wire [7:0] trig_s = clean[3*NUM_CTR+7:3*NUM_CTR];
  wire ref_s = clean[NSYNC-1];

  ////////////////////////////////////////////////////////////////////////////
  // Timebases from the local clock; slower rates are enables
  // local oscillator
  logic [$clog2(SLOW_DIV)-1:0] slow_cnt;
  logic [4:0] mid_acc;
  logic slow_tb, mid_tb;
  wire [5:0] mid_sum = {1'b0, mid_acc} + 6'(MID_KHZ / 1000);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_cnt <= '0;
      mid_acc <= '0;
      slow_tb <= 1'b0;
      mid_tb <= 1'b0;
    end else begin
      slow_tb <= (slow_cnt == $bits(slow_cnt)'(SLOW_DIV - 1));
      slow_cnt <= (slow_cnt == $bits(slow_cnt)'(SLOW_DIV - 1)) ? '0 : slow_cnt + 1'b1;
      // Fractional divider: 20 of every 25 clocks yield a tick
      mid_tb <= (mid_sum >= 6'(CLK_KHZ / 1000));
      mid_acc <= (mid_sum >= 6'(CLK_KHZ / 1000)) ? 5'(mid_sum - 6'(CLK_KHZ / 1000)) : mid_sum[4:0];
    end
  end
  // Fastest timebase: every clock when present, else falls back to mid rate
  wire fast_tb = (HAS_FAST != 0) ? 1'b1 : mid_tb;

  ////////////////////////////////////////////////////////////////////////////
  // Reference-clock presence and lock control
  // loss detect
  logic ref_d;
  logic [4:0] ref_quiet;
  logic [2:0] glob;
  wire ref_edge = ref_s & ~ref_d;
  wire ref_present = (ref_quiet < 5'(REF_LOSS_CYC));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_d <= 1'b0;
      ref_quiet <= 5'h1F;
    end else begin
      ref_d <= ref_s;
      // Saturates at the loss limit so a stopped reference never wraps back to present
      ref_quiet <= ref_edge ? 5'h00 : (ref_present ? ref_quiet + 5'h01 : ref_quiet);
    end
  end
  assign ref_locked = glob[G_PXI] & glob[G_PLL_EN] & ref_present;

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [CTRL_W-1:0] ctrl [NUM_CTR];
  logic [CTR_W-1:0] load [NUM_CTR];
  logic [CTR_W-1:0] count [NUM_CTR];
  logic [CTR_W-1:0] latch [NUM_CTR];
  logic [NUM_CTR-1:0] armed, running, aux_flag, term_q, out_lvl;

  // APB decode; zero-wait answer
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire ctr_space = (paddr[11:8] == 4'h0);
  wire [2:0] idx = paddr[7:5];
  wire [11:0] roff = {7'h00, paddr[4:0]};
  wire glob_hit = (paddr == OFF_GLOBAL);
  wire stat_hit = (paddr == OFF_STATUS);
  wire reg_hit = ctr_space & (roff <= OFF_CMD) & (paddr[1:0] == 2'b00);
  assign pready = 1'b1;
  assign pslverr = acc & ~(reg_hit | glob_hit | stat_hit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      glob <= GLOBAL_RST;
    end else if (wr && glob_hit) begin
      glob <= pwdata[2:0];
    end
  end

  // Read mux registered data
  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (glob_hit) next_prdata = {29'h0, glob};
    else if (stat_hit) next_prdata = {7'h00, ref_present, aux_flag, running, armed};
    else if (ctr_space) begin
      unique case (roff)
        OFF_CTRL: next_prdata = {{(32 - CTRL_W){1'b0}}, ctrl[idx]};
        OFF_LOAD: next_prdata = load[idx];
        OFF_COUNT: next_prdata = count[idx];
        OFF_LATCH: next_prdata = latch[idx];
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) prdata <= next_prdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arm trigger edges, shared across counters
  // common arm event
  logic [7:0] trig_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) trig_d <= 8'h00;
    else trig_d <= trig_s;
  end
  wire [7:0] trig_rise = trig_s & ~trig_d;

  ////////////////////////////////////////////////////////////////////////////
  // Per-counter logic
  genvar n;
  generate
    for (n = 0; n < NUM_CTR; n++) begin : g_ctr
      wire [CTRL_W-1:0] c = ctrl[n];
      wire sel_w = wr & ctr_space & (idx == 3'(n));
      wire cmd_w = sel_w & (roff == OFF_CMD);
      // Timebase select per counter
      wire tb_tick = (c[F_TB_SEL+:2] == 2'b01) ? slow_tb :
                     (c[F_TB_SEL+:2] == 2'b10) ? mid_tb :
                     (c[F_TB_SEL+:2] == 2'b11) ? fast_tb : 1'b0;
      logic src_d, aux_d;
      wire src_edge = c[F_SRC_EDGE] ? (~src_s[n] & src_d) : (src_s[n] & ~src_d);
      wire count_tick = (c[F_TB_SEL+:2] == 2'b00) ? src_edge : tb_tick;
      // partner output to gate
      // Partner's internal output, after its polarity, as software sees it
      wire partner_out = counter_terminal_output[n ^ 1];
      wire gate_lvl = c[F_PAIR_GATE] ? partner_out : gate_s[n];
      wire gate_ok = ~c[F_GATE_EN] | gate_lvl;
      wire aux_edge = c[F_AUX_EDGE] ? (~aux_s[n] & aux_d) : (aux_s[n] & ~aux_d);
      wire [1:0] amode = c[F_AUX_MODE+:2];
      wire down = c[F_AUX_DIR] & aux_s[n];
      wire hw_arm = c[F_ARM_HW] & trig_rise[c[F_ARM_SEL+:3]];
      wire sw_arm = cmd_w & pwdata[C_ARM];
      wire ss_edge = (amode == CSR_AUX_STARTSTOP) & aux_edge;
      wire step = armed[n] & running[n] & gate_ok & count_tick & c[F_EN];
      wire roll = step & (down ? (count[n] == '0) : (count[n] == '1));
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ctrl[n] <= CTRL_RST;
          load[n] <= '0;
          count[n] <= '0;
          latch[n] <= '0;
          armed[n] <= 1'b0;
          running[n] <= 1'b0;
          aux_flag[n] <= 1'b0;
          term_q[n] <= 1'b0;
          out_lvl[n] <= 1'b0;
          src_d <= 1'b0;
          aux_d <= 1'b0;
        end else begin
          src_d <= src_s[n];
          aux_d <= aux_s[n];
          if (sel_w && roff == OFF_CTRL) ctrl[n] <= pwdata[CTRL_W-1:0];
          if (sel_w && roff == OFF_LOAD) load[n] <= pwdata;
          if (sel_w && roff == OFF_LOAD) count[n] <= pwdata;
          else if (roll) count[n] <= load[n];
          else if (step) count[n] <= down ? count[n] - 1'b1 : count[n] + 1'b1;
          if (amode == CSR_AUX_LATCH && aux_edge) latch[n] <= count[n];
          // aux event flag, set wins over clear
          if (amode == CSR_AUX_EVENT && aux_edge) aux_flag[n] <= 1'b1;
          else if (sel_w && roff == OFF_CMD && pwdata[2]) aux_flag[n] <= 1'b0;
          if (sw_arm || hw_arm) armed[n] <= 1'b1;
          else if ((cmd_w && pwdata[C_DISARM]) || (roll && !c[F_CONT])) armed[n] <= 1'b0;
          if (amode != CSR_AUX_STARTSTOP) running[n] <= 1'b1;
          else if (ss_edge) running[n] <= ~running[n];
          term_q[n] <= step & (down ? (count[n] == CTR_W'(1)) : (count[n] == {{(CTR_W-1){1'b1}}, 1'b0}));
          if (roll) out_lvl[n] <= ~out_lvl[n];
        end
      end
      wire core = c[F_TOGGLE] ? out_lvl[n] : term_q[n];
      assign counter_terminal_output[n] = core ^ c[F_POL];
      assign counter_out_o[n] = core ^ c[F_POL];
      assign counter_out_oe[n] = c[F_OUT_EN];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Trigger bus drive
  // half mid-rate clock on line 7, toggled on each mid-rate tick
  logic mid_clk;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mid_clk <= 1'b0;
    else if (mid_tb) mid_clk <= ~mid_clk;
  end
  // outputs of counters 0..5 onto lines 0..5
  assign trigger_sync_bus_o = {mid_clk, 1'b0, counter_terminal_output[5:0]};
  assign trigger_sync_bus_oe = {glob[G_TB_DRIVE], 1'b0, 6'h00};
  assign star_trigger = glob[G_PXI] & trig_s[STAR_LINE];

endmodule

// *** tb/counter_signal_routing_bench.sv ***
`timescale 1ns/1ns
// Register-level bench for the counter routing block
module counter_signal_routing_bench;
  import csr_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pulse_req = 0, ref_run = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic pready, pslverr, err, count_pin, ref_clk, star, locked;
  logic [7:0] aux = 8'h00, trig_in = 8'h00, out_o, out_oe, term, trig_o, trig_oe;
  int failures = 0, compares = 0;
  always #20 pclk = ~pclk;
  csr_signal_source src (.pclk(pclk), .pulse_req(pulse_req), .ref_run(ref_run), .count_pin(count_pin),
    .ref_clk(ref_clk));
  csr_top #(.HAS_FAST(1)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .counter_count_input({7'h00, count_pin}), .counter_gate_input(8'h00), .counter_auxiliary_input(aux),
    .counter_out_o(out_o), .counter_out_oe(out_oe), .counter_terminal_output(term),
    .trigger_sync_bus_i(trig_in), .trigger_sync_bus_o(trig_o), .trigger_sync_bus_oe(trig_oe),
    .backplane_ref_clk(ref_clk), .star_trigger(star), .ref_locked(locked));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (failures == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One count pulse, then time for the synchronizer
  task automatic pulse();
    pulse_req <= 1'b1;
    @(posedge pclk);
    pulse_req <= 1'b0;
    repeat (14) @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("out_oe", {24'h0, out_oe}, 32'h0);
    check("line7_oe", {31'h0, trig_oe[7]}, 32'h0);
    apb(1'b0, OFF_GLOBAL, 32'h0);
    check("global", rd, 32'h2);
    apb(1'b0, 12'h200, 32'h0);
    check("unmapped", {31'h0, err}, 32'h1);
    apb(1'b1, OFF_GLOBAL, 32'h3);
    repeat (2) @(posedge pclk);
    check("line7_on", {31'h0, trig_oe[7]}, 32'h1);
    // Counter 0: pin source, toggle, pin enabled, continuous, aux latches count
    apb(1'b1, OFF_LOAD, 32'hFFFFFFFE);
    apb(1'b1, OFF_CTRL, 32'h00000515);
    apb(1'b1, OFF_CMD, 32'h1);
    check("pin_oe", {31'h0, out_oe[0]}, 32'h1);
    pulse();
    apb(1'b0, OFF_COUNT, 32'h0);
    check("count", rd, 32'hFFFFFFFF);
    aux[0] <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(1'b0, OFF_LATCH, 32'h0);
    check("latch", rd, 32'hFFFFFFFF);
    apb(1'b0, OFF_STATUS, 32'h0);
    check("aux_flag_latch", {31'h0, rd[16]}, 32'h0);
    pulse();
    check("toggle", {31'h0, term[0]}, 32'h1);
    apb(1'b0, OFF_COUNT, 32'h0);
    check("reload", rd, 32'hFFFFFFFE);
    apb(1'b1, OFF_CTRL, 32'h0000051D);
    @(posedge pclk);
    check("invert", {31'h0, term[0]}, 32'h0);
    check("pin_out", {31'h0, out_o[0]}, 32'h0);
    check("bus_line0", {31'h0, trig_o[0]}, 32'h0);
    // Event mode: rising aux edge sets the flag, command bit 2 clears it
    aux[0] <= 1'b0;
    apb(1'b1, OFF_CTRL, 32'h0000071D);
    aux[0] <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(1'b0, OFF_STATUS, 32'h0);
    check("aux_flag_set", {31'h0, rd[16]}, 32'h1);
    apb(1'b1, OFF_CMD, 32'h4);
    apb(1'b0, OFF_STATUS, 32'h0);
    check("aux_flag_clr", {31'h0, rd[16]}, 32'h0);
    // Counters 2 and 3 share hardware arm on trigger line 1
    apb(1'b1, 12'h040, 32'h00008020);
    apb(1'b1, 12'h060, 32'h00008020);
    apb(1'b0, OFF_STATUS, 32'h0);
    check("not_armed", {30'h0, rd[3:2]}, 32'h0);
    trig_in[1] <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(1'b0, OFF_STATUS, 32'h0);
    check("hw_armed", {30'h0, rd[3:2]}, 32'h3);
    // Backplane variant: lock, star trigger, loss of reference
    trig_in[6] <= 1'b1;
    ref_run <= 1'b1;
    apb(1'b1, OFF_GLOBAL, 32'h6);
    repeat (100) @(posedge pclk);
    check("locked", {31'h0, locked}, 32'h1);
    check("star", {31'h0, star}, 32'h1);
    apb(1'b1, OFF_GLOBAL, 32'h4);
    repeat (30) @(posedge pclk);
    check("lock_off", {31'h0, locked}, 32'h0);
    apb(1'b1, OFF_GLOBAL, 32'h6);
    repeat (100) @(posedge pclk);
    ref_run <= 1'b0;
    repeat (80) @(posedge pclk);
    check("ref_lost", {31'h0, locked}, 32'h0);
    apb(1'b0, OFF_STATUS, 32'h0);
    check("ref_present", {31'h0, rd[24]}, 32'h0);
    final_report();
  end
endmodule

// *** tb/csr_signal_source.sv ***
`timescale 1ns/1ns
// Far side: an external count source and the backplane reference
module csr_signal_source (
  // Clock and requests
  input wire logic pclk,
  input wire logic pulse_req,
  input wire logic ref_run,
  // Driven pins
  output logic count_pin,
  output logic ref_clk
);
  logic [3:0] phase = 4'h0;
  // One pulse, 4 high then 4 low, longer than the input synchronizer delay
  always @(posedge pclk) begin
    if (phase != 4'h0) begin
      phase <= phase - 4'h1;
    end else if (pulse_req) begin
      phase <= 4'h8;
    end
  end
  assign count_pin = phase > 4'h4;
  // Reference stops low when the chassis has none; the odd 51 ns half period meets a rising clock edge once in 40 toggles
  initial ref_clk = 1'b0;
  always #51 ref_clk = ref_run ? ~ref_clk : 1'b0;
endmodule

// *** tb/csr_top_assertions.sv ***
`timescale 1ns/1ns
// Port checker for the counter routing block
module csr_assert_chk (
  // Clock and APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Counter and bus outputs, backplane reference and lock
  input wire logic [7:0] counter_out_o,
  input wire logic [7:0] counter_out_oe,
  input wire logic [7:0] counter_terminal_output,
  input wire logic [7:0] trigger_sync_bus_oe,
  input wire logic backplane_ref_clk,
  input wire logic ref_locked
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic ref_q;
  logic [5:0] still;
  // Cycles since the reference last moved, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_q <= 1'b0;
      still <= 6'h00;
    end else begin
      ref_q <= backplane_ref_clk;
      still <= (backplane_ref_clk != ref_q) ? 6'h00 : (still == 6'h3F ? still : still + 6'h01);
    end
  end
  sequence s_released;
    $rose(presetn);
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  a_oe_after_reset: assert property (s_released |-> (counter_out_oe == 8'h00)[*2])
    else $error("output enable set right after reset");
  a_line7_default: assert property (s_released |-> !trigger_sync_bus_oe[7])
    else $error("line 7 driven after reset");
  a_lines_undriven: assert property (trigger_sync_bus_oe[5:0] == 6'h00)
    else $error("data trigger lines driven");
  a_zero_wait: assert property (s_access |-> pready)
    else $error("access not answered at once");
  a_unmapped_error: assert property (s_access ##0 (paddr == 12'h200) |-> pslverr)
    else $error("unmapped access without error");
  a_mapped_ok: assert property (s_access ##0 (paddr == 12'h100) |-> !pslverr)
    else $error("mapped access flagged");
  a_pin_follows: assert property ((counter_out_oe & (counter_out_o ^ counter_terminal_output)) == 8'h00)
    else $error("enabled pin differs from internal output");
  a_ref_loss_unlock: assert property (still >= 6'd40 |-> !ref_locked)
    else $error("lock held without reference");
  a_rdata_holds: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved outside read setup");
endmodule
bind csr_top csr_assert_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .counter_out_o(counter_out_o), .counter_out_oe(counter_out_oe),
  .counter_terminal_output(counter_terminal_output), .trigger_sync_bus_oe(trigger_sync_bus_oe),
  .backplane_ref_clk(backplane_ref_clk), .ref_locked(ref_locked));
